/* pkt_fifo_datapath.sv */
`timescale 1ns/1ps
module pkt_fifo_datapath (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [1:0] chip_mode,
	input wire logic packet_mode,
	input wire logic packet_format_select,
	input wire logic [6:0] payload_length,
	input wire logic crc_enable,
	input wire logic [1:0] fifo_depth_select,
	input wire logic [5:0] fifo_level_threshold,
	input wire logic [1:0] rx_irq_a_select,
	input wire logic [1:0] rx_irq_b_select,
	input wire logic tx_start_condition,
	input wire logic tx_irq_b_select,
	input wire logic fill_method,
	input wire logic fill_control,
	input wire logic sync_match_enable,
	input wire logic bit_sync_enable,
	input wire logic [31:0] sync_word,
	input wire logic sync_found,
	input wire logic signal_strength_flag,
	input wire logic overrun_clear,
	input wire logic bit_clk,
	input wire logic rx_bit,
	input wire logic host_wr,
	input wire logic [7:0] host_wr_data,
	input wire logic host_rd,
	output logic [7:0] host_rd_data,
	output logic host_rd_valid,
	output logic tx_bit,
	output logic irq_out_a,
	output logic irq_out_b,
	output logic fifo_empty_flag,
	output logic fifo_full_flag,
	output logic fifo_threshold_flag,
	output logic overrun_flag,
	output logic transmit_done_flag,
	output logic byte_written_flag,
	output logic crc_ok,
	output logic sync_active,
	output logic bit_sync_active
);
	fifo_mem_if mif ();
	fifo_byte_mem u_mem (.clk_sys(clk_sys), .port(mif.mem));

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
		crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? pkt_fifo_pkg::CRC_POLY : 16'h0000);
	endfunction : crc_step

	// ==========================================================
	// link sampling
	// three stages; a level counts once stages two and three agree
	logic [2:0] clk_s, dat_s;
	logic clk_f, dat_f, bit_edge;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			clk_s <= 3'h0;
			dat_s <= 3'h0;
			clk_f <= 1'b0;
			dat_f <= 1'b0;
		end else begin
			clk_s <= {clk_s[1:0], bit_clk};
			dat_s <= {dat_s[1:0], rx_bit};
			clk_f <= (clk_s[2] == clk_s[1]) ? clk_s[2] : clk_f;
			dat_f <= (dat_s[2] == dat_s[1]) ? dat_s[2] : dat_f;
		end
	end
	assign bit_edge = !clk_f && clk_s[2] && clk_s[1];

	// ==========================================================
	// mode decode
	logic in_rx, in_tx, in_sb;
	logic [6:0] depth, eff_len;
	assign in_rx = chip_mode == pkt_fifo_pkg::MODE_RX;
	assign in_tx = chip_mode == pkt_fifo_pkg::MODE_TX;
	assign in_sb = chip_mode == pkt_fifo_pkg::MODE_STANDBY;
	assign sync_active = packet_mode || sync_match_enable;
	assign bit_sync_active = packet_mode || bit_sync_enable;
	assign depth = {1'b0, fifo_depth_select, 4'h0} + pkt_fifo_pkg::DEPTH_UNIT;
	// payload never longer than the queue can hold
	assign eff_len = (payload_length > depth) ? depth : payload_length;

	// ==========================================================
	// byte queue
	logic [5:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [6:0] fifo_count, next_count;
	logic push, pop, push_ok, pop_ok, next_rd_valid, rx_push, tx_pop;
	logic [7:0] rx_data;
	assign fifo_full_flag = fifo_count == depth;
	assign fifo_empty_flag = fifo_count == 7'h00;
	always_comb begin
		// host may fill and drain from stand-by as well
		push = in_rx ? rx_push : host_wr;
		pop = in_tx ? tx_pop : host_rd;
		push_ok = push && !fifo_full_flag;
		pop_ok = pop && !fifo_empty_flag;
		next_count = fifo_count + {6'h00, push_ok} - {6'h00, pop_ok};
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		if (push_ok) begin
			next_wr_ptr = ({1'b0, wr_ptr} == depth - 7'h01) ? 6'h00 : wr_ptr + 6'h01;
		end
		if (pop_ok) begin
			next_rd_ptr = ({1'b0, rd_ptr} == depth - 7'h01) ? 6'h00 : rd_ptr + 6'h01;
		end
		next_rd_valid = pop_ok && !in_tx;
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wr_ptr <= 6'h00;
			rd_ptr <= 6'h00;
			fifo_count <= 7'h00;
			host_rd_valid <= 1'b0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			fifo_count <= next_count;
			host_rd_valid <= next_rd_valid;
		end
	end
	assign mif.wr_en = push_ok;
	assign mif.wr_addr = wr_ptr;
	assign mif.wr_data = in_rx ? rx_data : host_wr_data;
	assign mif.rd_en = pop_ok;
	assign mif.rd_addr = rd_ptr;
	assign host_rd_data = mif.rd_data;

	// ==========================================================
	// transmit framer
	pkt_fifo_pkg::tx_state_t tx_state, next_tx_state;
	pkt_fifo_pkg::tx_phase_t tx_phase, next_tx_phase;
	logic [7:0] tx_shift, next_tx_shift;
	logic [2:0] tx_bits, next_tx_bits;
	logic [6:0] tx_cnt, next_tx_cnt;
	logic [15:0] tx_crc, next_tx_crc;
	logic [31:0] sync_rot;
	logic framed, tx_go;
	assign framed = packet_mode && !packet_format_select;
	always_comb begin
		next_tx_state = tx_state;
		next_tx_phase = tx_phase;
		next_tx_shift = tx_shift;
		next_tx_bits = tx_bits;
		next_tx_cnt = tx_cnt;
		next_tx_crc = tx_crc;
		tx_pop = 1'b0;
		sync_rot = sync_word << {tx_cnt + 7'h01, 3'h0};
		tx_go = tx_start_condition ? !fifo_empty_flag
			: (framed ? fifo_count >= {1'b0, fifo_level_threshold} : fifo_full_flag);
		// leaving transmit stops at once, unsent data stays queued
		if (!in_tx) begin
			next_tx_state = pkt_fifo_pkg::TX_IDLE;
		end else begin
			case (tx_state)
				pkt_fifo_pkg::TX_IDLE: begin
					if (tx_go && framed) begin
						next_tx_phase = pkt_fifo_pkg::PH_PRE;
						next_tx_shift = pkt_fifo_pkg::PREAMBLE_BYTE;
						next_tx_cnt = 7'h00;
						next_tx_bits = 3'h0;
						next_tx_crc = pkt_fifo_pkg::CRC_INIT;
						next_tx_state = pkt_fifo_pkg::TX_SHIFT;
					end else if (tx_go) begin
						next_tx_phase = pkt_fifo_pkg::PH_PAY;
						tx_pop = 1'b1;
						next_tx_state = pkt_fifo_pkg::TX_FETCH;
					end
				end
				pkt_fifo_pkg::TX_FETCH: begin
					next_tx_shift = mif.rd_data;
					next_tx_bits = 3'h0;
					next_tx_state = pkt_fifo_pkg::TX_SHIFT;
				end
				pkt_fifo_pkg::TX_SHIFT: begin
					if (bit_edge) begin
						if (tx_phase == pkt_fifo_pkg::PH_PAY) begin
							next_tx_crc = crc_step(tx_crc, tx_shift[7]);
						end
						next_tx_shift = {tx_shift[6:0], 1'b0};
						next_tx_bits = tx_bits + 3'h1;
						if (tx_bits == pkt_fifo_pkg::LAST_BIT) begin
							// byte boundary: pick what goes next in the frame
							next_tx_bits = 3'h0;
							next_tx_cnt = tx_cnt + 7'h01; // counts bytes, not bits
							case (tx_phase)
								pkt_fifo_pkg::PH_PRE: begin
									next_tx_shift = pkt_fifo_pkg::PREAMBLE_BYTE;
									if (next_tx_cnt == pkt_fifo_pkg::PREAMBLE_COUNT) begin
										next_tx_phase = pkt_fifo_pkg::PH_SYNC;
										next_tx_cnt = 7'h00;
										next_tx_shift = sync_word[31:24];
									end
								end
								pkt_fifo_pkg::PH_SYNC: begin
									next_tx_shift = sync_rot[31:24];
									if (next_tx_cnt == pkt_fifo_pkg::SYNC_COUNT) begin
										next_tx_phase = pkt_fifo_pkg::PH_PAY;
										next_tx_cnt = 7'h00;
										tx_pop = 1'b1;
										next_tx_state = pkt_fifo_pkg::TX_FETCH;
									end
								end
								pkt_fifo_pkg::PH_PAY: begin
									if (!framed) begin
										// unlimited length: run while bytes remain
										tx_pop = !fifo_empty_flag;
										next_tx_state = fifo_empty_flag ? pkt_fifo_pkg::TX_DONE
											: pkt_fifo_pkg::TX_FETCH;
									end else if (next_tx_cnt != eff_len) begin
										tx_pop = 1'b1;
										next_tx_state = pkt_fifo_pkg::TX_FETCH;
									end else if (crc_enable) begin
										next_tx_phase = pkt_fifo_pkg::PH_CRC;
										next_tx_cnt = 7'h00;
										next_tx_shift = next_tx_crc[15:8];
									end else begin
										next_tx_state = pkt_fifo_pkg::TX_DONE;
									end
								end
								default: begin
									next_tx_shift = tx_crc[7:0];
									if (next_tx_cnt == pkt_fifo_pkg::CRC_COUNT) begin
										next_tx_state = pkt_fifo_pkg::TX_DONE;
									end
								end
							endcase
						end
					end
				end
				default: ;
			endcase
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tx_state <= pkt_fifo_pkg::TX_IDLE;
			tx_phase <= pkt_fifo_pkg::PH_PRE;
			tx_shift <= 8'h00;
			tx_bits <= 3'h0;
			tx_cnt <= 7'h00;
			tx_crc <= pkt_fifo_pkg::CRC_INIT;
		end else begin
			tx_state <= next_tx_state;
			tx_phase <= next_tx_phase;
			tx_shift <= next_tx_shift;
			tx_bits <= next_tx_bits;
			tx_cnt <= next_tx_cnt;
			tx_crc <= next_tx_crc;
		end
	end
	assign tx_bit = tx_shift[7];
	assign transmit_done_flag = tx_state == pkt_fifo_pkg::TX_DONE;

	// ==========================================================
	// receive deframer
	pkt_fifo_pkg::rx_phase_t rx_phase, next_rx_phase;
	logic [7:0] rx_shift, next_rx_shift;
	logic [2:0] rx_bits, next_rx_bits;
	logic [6:0] rx_cnt, next_rx_cnt;
	logic [15:0] rx_crc, next_rx_crc;
	logic sync_seen, next_sync_seen, was_rx, next_overrun, next_crc_ok, rx_fill, rx_byte;
	assign rx_data = {rx_shift[6:0], dat_f};
	always_comb begin
		next_rx_phase = rx_phase;
		next_rx_shift = rx_shift;
		next_rx_bits = rx_bits;
		next_rx_cnt = rx_cnt;
		next_rx_crc = rx_crc;
		next_sync_seen = sync_seen;
		next_crc_ok = crc_ok;
		next_overrun = overrun_flag && !overrun_clear;
		rx_push = 1'b0;
		rx_byte = 1'b0;
		rx_fill = framed ? (rx_phase == pkt_fifo_pkg::RX_PAY)
			: (fill_method ? fill_control : sync_seen);
		if (!in_rx) begin
			next_rx_bits = 3'h0;
			next_rx_phase = pkt_fifo_pkg::RX_HUNT;
		end else if (!was_rx) begin
			next_sync_seen = 1'b0;
			next_rx_bits = 3'h0;
		end else if (sync_found && sync_active) begin
			// realign to the byte after the sync word
			next_sync_seen = 1'b1;
			next_rx_bits = 3'h0;
			if (rx_phase == pkt_fifo_pkg::RX_HUNT) begin
				next_rx_phase = pkt_fifo_pkg::RX_PAY;
				next_rx_cnt = 7'h00;
				next_rx_crc = pkt_fifo_pkg::CRC_INIT;
				next_crc_ok = 1'b0;
			end
		end else if (bit_edge) begin
			next_rx_shift = rx_data;
			next_rx_bits = rx_bits + 3'h1;
			next_rx_crc = crc_step(rx_crc, dat_f);
			if (rx_bits == pkt_fifo_pkg::LAST_BIT) begin
				rx_byte = rx_fill;
				rx_push = rx_byte && !fifo_full_flag;
				next_overrun = next_overrun || (rx_byte && fifo_full_flag);
				next_rx_cnt = rx_cnt + 7'h01;
				if (rx_phase == pkt_fifo_pkg::RX_PAY && next_rx_cnt == eff_len) begin
					next_rx_phase = crc_enable ? pkt_fifo_pkg::RX_CRC : pkt_fifo_pkg::RX_END;
					next_rx_cnt = 7'h00;
				end else if (rx_phase == pkt_fifo_pkg::RX_CRC
					&& next_rx_cnt == pkt_fifo_pkg::CRC_COUNT) begin
					// remainder is zero when data and checksum agree
					next_crc_ok = next_rx_crc == 16'h0000;
					next_rx_phase = pkt_fifo_pkg::RX_END;
				end
			end
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rx_phase <= pkt_fifo_pkg::RX_HUNT;
			rx_shift <= 8'h00;
			rx_bits <= 3'h0;
			rx_cnt <= 7'h00;
			rx_crc <= pkt_fifo_pkg::CRC_INIT;
			sync_seen <= 1'b0;
			was_rx <= 1'b0;
			overrun_flag <= 1'b0;
			crc_ok <= 1'b0;
			byte_written_flag <= 1'b0;
		end else begin
			rx_phase <= next_rx_phase;
			rx_shift <= next_rx_shift;
			rx_bits <= next_rx_bits;
			rx_cnt <= next_rx_cnt;
			rx_crc <= next_rx_crc;
			sync_seen <= next_sync_seen;
			was_rx <= in_rx;
			overrun_flag <= next_overrun;
			crc_ok <= next_crc_ok;
			byte_written_flag <= rx_push && push_ok;
		end
	end
	assign fifo_threshold_flag = sync_seen && fifo_count >= {1'b0, fifo_level_threshold};

	// ==========================================================
	// interrupt routing, registered levels
	logic next_irq_a, next_irq_b;
	always_comb begin
		next_irq_a = 1'b0;
		next_irq_b = 1'b0;
		if (in_tx) begin
			next_irq_a = fifo_empty_flag;
			next_irq_b = tx_irq_b_select ? transmit_done_flag : fifo_full_flag;
		end else if (in_rx || in_sb) begin
			// stand-by keeps only the queue-state sources
			case (rx_irq_a_select)
				pkt_fifo_pkg::IRQA_BYTE: next_irq_a = in_rx && byte_written_flag;
				pkt_fifo_pkg::IRQA_EMPTY: next_irq_a = fifo_empty_flag;
				pkt_fifo_pkg::IRQA_SYNC: next_irq_a = in_rx && sync_seen;
				default: next_irq_a = 1'b0;
			endcase
			case (rx_irq_b_select)
				pkt_fifo_pkg::IRQB_FULL: next_irq_b = fifo_full_flag;
				pkt_fifo_pkg::IRQB_SIGNAL_STRENGTH_FLAG: next_irq_b = in_rx && signal_strength_flag;
				pkt_fifo_pkg::IRQB_THRESH: next_irq_b = fifo_threshold_flag;
				default: next_irq_b = 1'b0;
			endcase
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irq_out_a <= 1'b0;
			irq_out_b <= 1'b0;
		end else begin
			irq_out_a <= next_irq_a;
			irq_out_b <= next_irq_b;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_irq_a_tx: assert property (in_tx |=> irq_out_a == $past(fifo_empty_flag))
		else $error("irq a not following empty in transmit");
	a_irq_b_tx: assert property (in_tx && tx_irq_b_select |=> irq_out_b == $past(transmit_done_flag))
		else $error("irq b not following done in transmit");
	a_irq_none_sel: assert property (in_rx && rx_irq_a_select == pkt_fifo_pkg::IRQA_NONE |=> !irq_out_a)
		else $error("irq a active with no source");
	a_irq_a_sync: assert property (in_rx && rx_irq_a_select == pkt_fifo_pkg::IRQA_SYNC |=> irq_out_a == $past(sync_seen))
		else $error("irq a not following sync");
	a_irq_b_signal_strength_flag: assert property (in_rx && rx_irq_b_select == pkt_fifo_pkg::IRQB_SIGNAL_STRENGTH_FLAG |=> irq_out_b == $past(signal_strength_flag))
		else $error("irq b not following signal strength");
	a_thresh_cause: assert property (fifo_threshold_flag |-> sync_seen && fifo_count >= {1'b0, fifo_level_threshold})
		else $error("threshold flag without cause");
	a_partial_drop: assert property (in_rx ##1 !in_rx |=> rx_bits == 3'h0)
		else $error("partial byte kept after receive");
	a_depth_bound: assert property (fifo_count <= depth)
		else $error("fill passed selected depth");
	a_pkt_sync_on: assert property (packet_mode |-> sync_active && bit_sync_active)
		else $error("packet mode without sync enables");
	a_tx_start: assert property (in_tx && tx_state == pkt_fifo_pkg::TX_IDLE && tx_start_condition && !fifo_empty_flag && !framed |=> tx_state == pkt_fifo_pkg::TX_FETCH)
		else $error("transmit did not start on first byte");
	a_overrun_set: assert property (in_rx && rx_byte && fifo_full_flag |=> overrun_flag && $stable(fifo_count))
		else $error("overrun not raised or byte stored");
	a_frame_order: assert property (tx_phase == pkt_fifo_pkg::PH_PAY && $past(tx_phase) != pkt_fifo_pkg::PH_PAY && framed && in_tx |-> $past(tx_phase) == pkt_fifo_pkg::PH_SYNC)
		else $error("payload not preceded by sync word");
	c_tx_done: cover property (in_tx && $rose(transmit_done_flag));
	c_overrun: cover property ($rose(overrun_flag));
	c_thresh_irq: cover property (in_rx && $rose(irq_out_b) && fifo_threshold_flag);
	c_crc_ok: cover property ($rose(crc_ok));
endmodule : pkt_fifo_datapath

/* pkt_fifo_pkg.sv */
package pkt_fifo_pkg;
	localparam int ADDR_W = 6;
	localparam logic [6:0] DEPTH_UNIT = 7'h10;
	localparam logic [1:0] MODE_STANDBY = 2'h0;
	localparam logic [1:0] MODE_RX = 2'h1;
	localparam logic [1:0] MODE_TX = 2'h2;
	localparam logic [1:0] IRQA_NONE = 2'h0;
	localparam logic [1:0] IRQA_BYTE = 2'h1;
	localparam logic [1:0] IRQA_EMPTY = 2'h2;
	localparam logic [1:0] IRQA_SYNC = 2'h3;
	localparam logic [1:0] IRQB_NONE = 2'h0;
	localparam logic [1:0] IRQB_FULL = 2'h1;
	localparam logic [1:0] IRQB_SIGNAL_STRENGTH_FLAG = 2'h2;
	localparam logic [1:0] IRQB_THRESH = 2'h3;
	localparam logic [7:0] PREAMBLE_BYTE = 8'hAA;
	localparam logic [6:0] PREAMBLE_COUNT = 7'h03;
	localparam logic [6:0] SYNC_COUNT = 7'h04;
	localparam logic [6:0] CRC_COUNT = 7'h02;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [2:0] LAST_BIT = 3'h7;
	typedef enum logic [1:0] {TX_IDLE, TX_FETCH, TX_SHIFT, TX_DONE} tx_state_t;
	typedef enum logic [1:0] {PH_PRE, PH_SYNC, PH_PAY, PH_CRC} tx_phase_t;
	typedef enum logic [1:0] {RX_HUNT, RX_PAY, RX_CRC, RX_END} rx_phase_t;
endpackage : pkt_fifo_pkg

/* fifo_mem_if.sv */
`timescale 1ns/1ps
// write and read ports of the byte store
interface fifo_mem_if;
	logic wr_en;
	logic [5:0] wr_addr;
	logic [7:0] wr_data;
	logic rd_en;
	logic [5:0] rd_addr;
	logic [7:0] rd_data;
	modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_en, output rd_addr,
		input rd_data);
	modport mem (input wr_en, input wr_addr, input wr_data, input rd_en, input rd_addr,
		output rd_data);
endinterface : fifo_mem_if

/* fifo_byte_mem.sv */
`timescale 1ns/1ps
// 64 byte store, read data registered
module fifo_byte_mem (
	input wire logic clk_sys,
	fifo_mem_if.mem port
);
	logic [7:0] store [64];
	logic [7:0] rd_q;

	// no reset on the array: contents are only read after being written
	always_ff @(posedge clk_sys) begin
		if (port.wr_en) begin
			store[port.wr_addr] <= port.wr_data;
		end
		if (port.rd_en) begin
			rd_q <= store[port.rd_addr];
		end
	end
	assign port.rd_data = rd_q;
endmodule : fifo_byte_mem

/* host_model.sv */
`timescale 1ns/1ps
// ==========================================
// host side of the byte port
// one request every two cycles, released at the taking edge
module host_model (
	input wire logic clk_sys,
	output logic host_wr,
	output logic [7:0] host_wr_data,
	output logic host_rd,
	input wire logic [7:0] host_rd_data,
	input wire logic host_rd_valid
);
	// idle levels from time zero
	initial begin
		host_wr = 1'b0;
		host_wr_data = 8'h00;
		host_rd = 1'b0;
	end
	// one byte written; data inverted once released so stale bytes never match
	task put(input logic [7:0] b);
		@(posedge clk_sys);
		host_wr <= 1'b1;
		host_wr_data <= b;
		@(posedge clk_sys);
		host_wr <= 1'b0;
		host_wr_data <= ~b;
	endtask : put
	// one read; ok low when the device refused it
	task get(output logic [7:0] b, output logic ok);
		@(posedge clk_sys);
		host_rd <= 1'b1;
		@(posedge clk_sys);
		host_rd <= 1'b0;
		#1;
		ok = host_rd_valid;
		b = host_rd_data;
	endtask : get
endmodule : host_model

/* tb_pkt_fifo_datapath.sv */
`timescale 1ns/1ps
// ==========================================
// bench for queue, interrupt routing and link shifting
module tb_pkt_fifo_datapath;
	logic clk_sys, rst, packet_mode, packet_format_select, crc_enable;
	logic [1:0] chip_mode, fifo_depth_select, rx_irq_a_select, rx_irq_b_select;
	logic [6:0] payload_length;
	logic [5:0] fifo_level_threshold;
	logic tx_start_condition, tx_irq_b_select, fill_method, fill_control;
	logic sync_match_enable, bit_sync_enable, sync_found, signal_strength_flag;
	logic [31:0] sync_word;
	logic overrun_clear, bit_clk, rx_bit, host_wr, host_rd, host_rd_valid, tx_bit;
	logic [7:0] host_wr_data, host_rd_data;
	logic irq_out_a, irq_out_b, fifo_empty_flag, fifo_full_flag, fifo_threshold_flag;
	logic overrun_flag, transmit_done_flag, byte_written_flag, crc_ok;
	logic sync_active, bit_sync_active;
	int n_errors = 0;
	int n_compared = 0;
	int n_written = 0;
	int n_irq_a = 0;
	// pulse counters, read mid-cycle where the registered pulses have settled
	always @(negedge clk_sys) begin
		if (byte_written_flag === 1'b1) n_written++;
		if (irq_out_a === 1'b1) n_irq_a++;
	end
	// ==========================================
	// instances
	pkt_fifo_datapath i_dut (.clk_sys, .rst, .chip_mode, .packet_mode, .packet_format_select,
		.payload_length, .crc_enable, .fifo_depth_select, .fifo_level_threshold,
		.rx_irq_a_select, .rx_irq_b_select, .tx_start_condition, .tx_irq_b_select,
		.fill_method, .fill_control, .sync_match_enable, .bit_sync_enable, .sync_word,
		.sync_found, .signal_strength_flag, .overrun_clear, .bit_clk, .rx_bit, .host_wr,
		.host_wr_data, .host_rd, .host_rd_data, .host_rd_valid, .tx_bit, .irq_out_a,
		.irq_out_b, .fifo_empty_flag, .fifo_full_flag, .fifo_threshold_flag, .overrun_flag,
		.transmit_done_flag, .byte_written_flag, .crc_ok, .sync_active, .bit_sync_active);
	host_model i_host (.clk_sys, .host_wr, .host_wr_data, .host_rd, .host_rd_data,
		.host_rd_valid);
	// ==========================================
	// shared helpers
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : cyc
	// one 160 ns link bit moved on clock edges; transmit data read just before the rise
	task link_bit(input logic b, output logic seen);
		rx_bit <= b;
		cyc(8);
		seen = tx_bit;
		bit_clk <= 1'b1;
		cyc(8);
		bit_clk <= 1'b0;
	endtask : link_bit
	// checksum of one byte, msb first, from the package polynomial and start value
	function automatic logic [15:0] exp_crc(input logic [7:0] d);
		logic [15:0] c;
		c = pkt_fifo_pkg::CRC_INIT;
		for (int i = 7; i >= 0; i--) begin
			c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? pkt_fifo_pkg::CRC_POLY : 16'h0000);
		end
		return c;
	endfunction : exp_crc
	task stop_test;
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : stop_test
	// ==========================================
	// scenarios
	task t_reset;
		check("empty", fifo_empty_flag, 1'b1);
		check("irq_a", irq_out_a, 1'b0);
		check("irq_b", irq_out_b, 1'b0);
		check("overrun", overrun_flag, 1'b0);
		check("tx_bit", tx_bit, 1'b0);
		check("rd valid", host_rd_valid, 1'b0);
		$display("test reset done");
	endtask : t_reset
	// every depth filled past full from stand-by, then drained in order
	task t_fill;
		logic [7:0] b;
		logic ok;
		int depth;
		rx_irq_a_select <= pkt_fifo_pkg::IRQA_EMPTY;
		rx_irq_b_select <= pkt_fifo_pkg::IRQB_FULL;
		for (int d = 0; d < 4; d++) begin
			fifo_depth_select <= 2'(d);
			depth = 16 * (d + 1);
			cyc(3);
			check("irq_a empty", irq_out_a, 1'b1);
			for (int i = 0; i <= depth; i++) begin
				i_host.put(8'(i * 7 + d));
			end
			cyc(2);
			check("full", fifo_full_flag, 1'b1);
			check("irq_b full", irq_out_b, 1'b1);
			for (int i = 0; i < depth; i++) begin
				i_host.get(b, ok);
				check("read data", {ok, b}, {1'b1, 8'(i * 7 + d)});
			end
			i_host.get(b, ok);
			check("extra read", ok, 1'b0);
			check("irq_b not full", irq_out_b, 1'b0);
		end
		$display("test fill done");
	endtask : t_fill
	task t_tx;
		logic [7:0] got;
		chip_mode <= pkt_fifo_pkg::MODE_TX;
		tx_irq_b_select <= 1'b1;
		cyc(3);
		check("tx irq_a", irq_out_a, 1'b1);
		tx_start_condition <= 1'b1;
		cyc(3);
		check("tx irq_a", irq_out_a, 1'b1);
		i_host.put(8'hA5);
		cyc(3);
		check("done early", irq_out_b, 1'b0);
		for (int i = 7; i >= 0; i--) begin
			link_bit(1'b0, got[i]);
		end
		cyc(6);
		check("tx bits", got, 8'hA5);
		check("done", transmit_done_flag, 1'b1);
		check("irq_b done", irq_out_b, 1'b1);
		check("irq_a after", irq_out_a, 1'b1);
		// a full bit period after done before leaving transmit
		cyc(16);
		chip_mode <= pkt_fifo_pkg::MODE_STANDBY;
		cyc(3);
		$display("test transmit done");
	endtask : t_tx
	// one whole byte after sync, then five loose bits that must vanish
	task t_rx;
		logic [7:0] b;
		logic ok;
		logic seen;
		logic [12:0] pat;
		pat = 13'h0796;
		fifo_level_threshold <= 6'h01;
		rx_irq_a_select <= pkt_fifo_pkg::IRQA_SYNC;
		rx_irq_b_select <= pkt_fifo_pkg::IRQB_SIGNAL_STRENGTH_FLAG;
		signal_strength_flag <= 1'b1;
		chip_mode <= pkt_fifo_pkg::MODE_RX;
		cyc(3);
		check("irq_b strength", irq_out_b, 1'b1);
		check("irq_a no sync", irq_out_a, 1'b0);
		sync_found <= 1'b1;
		cyc(1);
		sync_found <= 1'b0;
		rx_irq_b_select <= pkt_fifo_pkg::IRQB_THRESH;
		cyc(3);
		check("irq_a sync", irq_out_a, 1'b1);
		check("below level", fifo_threshold_flag, 1'b0);
		for (int i = 12; i >= 0; i--) begin
			link_bit(pat[i], seen);
			if (i == 5) begin
				cyc(6);
				check("level", {fifo_threshold_flag, irq_out_b}, 2'h3);
				check("stored", fifo_empty_flag, 1'b0);
			end
		end
		chip_mode <= pkt_fifo_pkg::MODE_STANDBY;
		rx_irq_b_select <= pkt_fifo_pkg::IRQB_SIGNAL_STRENGTH_FLAG;
		cyc(4);
		check("strength standby", irq_out_b, 1'b0);
		i_host.get(b, ok);
		check("rx byte", {ok, b}, {1'b1, 8'h3C});
		i_host.get(b, ok);
		check("loose bits gone", ok, 1'b0);
		signal_strength_flag <= 1'b0;
		$display("test receive done");
	endtask : t_rx
	// filling by the control bit alone, seventeen bytes into sixteen places
	task t_ovr;
		logic [7:0] b;
		logic ok;
		logic seen;
		fifo_depth_select <= 2'h0;
		fill_method <= 1'b1;
		fill_control <= 1'b1;
		rx_irq_a_select <= pkt_fifo_pkg::IRQA_BYTE;
		chip_mode <= pkt_fifo_pkg::MODE_RX;
		n_written = 0;
		n_irq_a = 0;
		cyc(3);
		for (int i = 0; i < 136; i++) begin
			link_bit(1'(i), seen);
		end
		cyc(3);
		check("bytes stored", n_written, 16);
		check("irq_a byte pulses", n_irq_a, 16);
		check("overrun", overrun_flag, 1'b1);
		overrun_clear <= 1'b1;
		cyc(1);
		overrun_clear <= 1'b0;
		cyc(2);
		check("overrun cleared", overrun_flag, 1'b0);
		chip_mode <= pkt_fifo_pkg::MODE_STANDBY;
		fill_method <= 1'b0;
		fill_control <= 1'b0;
		for (int i = 0; i < 16; i++) begin
			i_host.get(b, ok);
			check("overrun drain", {ok, b}, {1'b1, 8'h55});
		end
		i_host.get(b, ok);
		check("lost byte", ok, 1'b0);
		$display("test overrun done");
	endtask : t_ovr
	task t_pkt;
		logic [7:0] b;
		logic ok;
		logic seen;
		logic [79:0] frame;
		logic [23:0] rx_pat;
		packet_mode <= 1'b1;
		sync_match_enable <= 1'b0;
		bit_sync_enable <= 1'b0;
		cyc(2);
		check("sync forced", {sync_active, bit_sync_active}, 2'h3);
		i_host.put(8'h5A);
		i_host.get(b, ok);
		check("standby access", {ok, b}, {1'b1, 8'h5A});
		// one payload byte with checksum, sent as soon as it is queued
		crc_enable <= 1'b1;
		chip_mode <= pkt_fifo_pkg::MODE_TX;
		i_host.put(8'hC3);
		for (int i = 79; i >= 0; i--) begin
			link_bit(1'b0, frame[i]);
		end
		cyc(3);
		check("frame head", frame[79:48], {{3{pkt_fifo_pkg::PREAMBLE_BYTE}}, sync_word[31:24]});
		check("frame mid", frame[47:16], {sync_word[23:0], 8'hC3});
		check("frame crc", frame[15:0], exp_crc(8'hC3));
		check("frame done", transmit_done_flag, 1'b1);
		cyc(16);
		// the same byte and its checksum received after a sync hit
		chip_mode <= pkt_fifo_pkg::MODE_RX;
		rx_pat = {8'hC3, exp_crc(8'hC3)};
		cyc(3);
		sync_found <= 1'b1;
		cyc(1);
		sync_found <= 1'b0;
		for (int i = 23; i >= 0; i--) begin
			link_bit(rx_pat[i], seen);
		end
		cyc(3);
		check("crc ok", crc_ok, 1'b1);
		chip_mode <= pkt_fifo_pkg::MODE_STANDBY;
		cyc(2);
		i_host.get(b, ok);
		check("packet byte", {ok, b}, {1'b1, 8'hC3});
		i_host.get(b, ok);
		check("checksum not queued", ok, 1'b0);
		packet_mode <= 1'b0;
		crc_enable <= 1'b0;
		cyc(2);
		check("sync off", sync_active, 1'b0);
		$display("test packet done");
	endtask : t_pkt
	// ==========================================
	// clock, reset and sequence
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		rst = 1'b1;
		chip_mode = pkt_fifo_pkg::MODE_STANDBY;
		{packet_mode, packet_format_select, crc_enable} = 3'h0;
		payload_length = 7'h01;
		{fifo_depth_select, rx_irq_a_select, rx_irq_b_select} = 6'h00;
		fifo_level_threshold = 6'h00;
		{tx_start_condition, tx_irq_b_select, fill_method, fill_control} = 4'h0;
		{sync_match_enable, bit_sync_enable} = 2'h3;
		{sync_found, signal_strength_flag, overrun_clear, bit_clk, rx_bit} = 5'h00;
		sync_word = 32'h1234_5678;
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		cyc(3);
		t_reset;
		t_fill;
		t_tx;
		t_rx;
		t_ovr;
		t_pkt;
		stop_test;
	end
	// hang guard: far beyond the longest sequence
	initial begin
		#500000;
		n_errors++;
		stop_test;
	end
endmodule : tb_pkt_fifo_datapath
